/* File: hdl/ipv_pkg.sv */
package ipv_pkg;
    // =========================================================
    // Register map and field layout
    // =========================================================
    localparam logic [31:0] ADDR_PRIO_CTRL = 32'h0000_103c;
    localparam int          BIT_BOOT       = 7;
    localparam int          BIT_SPECIAL    = 6;
    localparam int          BIT_MODE_A     = 5;
    localparam int          BIT_VIS        = 4;
    localparam logic [3:0]  PSEL_RESET     = 4'h6;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // =========================================================
    // Maskable sources in default priority order
    // =========================================================
    localparam int          NUM_MASKABLE   = 15;
    localparam int          NUM_PERIPH     = 13;
    localparam logic [3:0]  SRC_IRQ        = 4'h0;
    localparam logic [3:0]  SRC_RTI        = 4'h1;
    localparam logic [3:0]  SRC_IC1        = 4'h2;
    localparam logic [3:0]  SRC_OC1        = 4'h5;
    localparam logic [3:0]  SRC_CAP4       = 4'h9;
    localparam logic [3:0]  SRC_TOF        = 4'ha;

    // =========================================================
    // Vector addresses
    // =========================================================
    localparam logic [15:0] VEC_IRQ        = 16'hfff2;
    localparam logic [15:0] VEC_STEP       = 16'h0002;
    localparam logic [15:0] VEC_NMI_PIN    = 16'hfff4;
    localparam logic [15:0] VEC_SW_TRAP    = 16'hfff6;
    localparam logic [15:0] VEC_ILLEGAL    = 16'hfff8;
    localparam logic [15:0] VEC_WATCHDOG   = 16'hfffa;
    localparam logic [15:0] VEC_CLKMON     = 16'hfffc;
    localparam logic [15:0] VEC_RESET      = 16'hfffe;

    // =========================================================
    // Stacking sequence
    // =========================================================
    localparam logic [3:0]  STACK_LAST     = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PUSH   = 2'b01,
        ST_VECTOR = 2'b10,
        ST_PULL   = 2'b11
    } ipv_state_e;
endpackage : ipv_pkg

/* File: hdl/ipv_ctrl.sv */
`timescale 1ns/1ps
module ipv_ctrl (
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        mode_pin_a_in,
    input  wire logic                        mode_pin_b_in,
    input  wire logic [31:0]                 s_axi_awaddr_in,
    input  wire logic                        s_axi_awvalid_in,
    output logic                             s_axi_awready_out,
    input  wire logic [31:0]                 s_axi_wdata_in,
    input  wire logic [3:0]                  s_axi_wstrb_in,
    input  wire logic                        s_axi_wvalid_in,
    output logic                             s_axi_wready_out,
    output logic [1:0]                       s_axi_bresp_out,
    output logic                             s_axi_bvalid_out,
    input  wire logic                        s_axi_bready_in,
    input  wire logic [31:0]                 s_axi_araddr_in,
    input  wire logic                        s_axi_arvalid_in,
    output logic                             s_axi_arready_out,
    output logic [31:0]                      s_axi_rdata_out,
    output logic [1:0]                       s_axi_rresp_out,
    output logic                             s_axi_rvalid_out,
    input  wire logic                        s_axi_rready_in,
    input  wire logic                        ext_request_n_in,
    input  wire logic                        nonmaskable_request_pin_n_in,
    input  wire logic [ipv_pkg::NUM_PERIPH-1:0] periph_flag_in,
    input  wire logic [ipv_pkg::NUM_PERIPH-1:0] periph_enable_in,
    input  wire logic [3:0]                  sci_flag_in,
    input  wire logic [3:0]                  sci_enable_in,
    input  wire logic                        rx_full_set_in,
    input  wire logic                        sci_status_rd_in,
    input  wire logic                        sci_data_rd_in,
    input  wire logic                        illegal_opcode_in,
    input  wire logic                        software_trap_in,
    input  wire logic                        watchdog_fail_in,
    input  wire logic                        watchdog_disable_in,
    input  wire logic                        clock_monitor_fail_in,
    input  wire logic                        clock_monitor_enable_in,
    input  wire logic                        global_mask_in,
    input  wire logic                        x_mask_in,
    input  wire logic                        instr_done_in,
    input  wire logic                        return_in,
    input  wire logic [15:0]                 stack_pointer_in,
    input  wire logic [71:0]                 frame_in,
    output logic                             stack_we_out,
    output logic                             stack_re_out,
    output logic [15:0]                      stack_addr_out,
    output logic [7:0]                       stack_data_out,
    output logic [3:0]                       restore_idx_out,
    output logic                             set_global_mask_out,
    output logic                             set_x_mask_out,
    output logic                             vector_valid_out,
    output logic [15:0]                      vector_addr_out,
    output logic                             busy_out,
    output logic                             read_visible_out,
    output logic                             clock_out_enable_out,
    output logic                             rx_full_out
);
    import ipv_pkg::*;

    typedef struct packed {
        ipv_state_e  st;
        logic [3:0]  step;
        logic [15:0] sp;
        logic [71:0] frame;
        logic        sel_x;
        logic [15:0] vec;
        logic        strap_done;
        logic        boot;
        logic        special;
        logic        mode_a;
        logic        vis;
        logic [3:0]  psel;
        logic        rx_full;
        logic        rx_armed;
        logic        awready;
        logic        wready;
        logic        aw_hit;
        logic [7:0]  wbyte;
        logic        wlane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        stack_we;
        logic        stack_re;
        logic [15:0] stack_addr;
        logic [7:0]  stack_data;
        logic [3:0]  restore_idx;
        logic        set_i;
        logic        set_x;
        logic        vec_valid;
        logic [15:0] vector;
        logic        busy;
        logic        read_vis;
        logic        clk_out_en;
    } ipv_regs_s;

    ipv_regs_s q;
    ipv_regs_s d;

    // =========================================================
    // Priority resolution
    // =========================================================
    function automatic logic [3:0] promoted_src(input logic [3:0] code);
        logic [3:0] s;
        s = SRC_IRQ;
        if (code <= 4'h4)
            s = 4'(SRC_TOF + code);
        else if (code == 4'h7)
            s = SRC_RTI;
        else if (code >= 4'h8 && code <= 4'ha)
            s = 4'(SRC_IC1 + code - 4'h8);
        else if (code >= 4'hb && code <= 4'he)
            s = 4'(SRC_OC1 + code - 4'hb);
        else if (code == 4'hf)
            s = SRC_CAP4;
        return s;
    endfunction : promoted_src

    logic [NUM_MASKABLE-1:0] m_req;
    logic                    sci_req;
    logic                    nmi_pin_req;
    logic                    nm_any;
    logic                    mk_any;
    logic                    start;
    logic [3:0]              win;
    logic [3:0]              prom;
    logic [15:0]             pick_vec;

    always_comb
    begin
        sci_req = ((q.rx_full | sci_flag_in[0]) & sci_enable_in[0])
                | |(sci_flag_in[3:1] & sci_enable_in[3:1]);
        m_req   = {sci_req, periph_flag_in & periph_enable_in, ~ext_request_n_in};
        nmi_pin_req = ~nonmaskable_request_pin_n_in & ~x_mask_in;
        nm_any  = (clock_monitor_fail_in & clock_monitor_enable_in)
                | (watchdog_fail_in & ~watchdog_disable_in)
                | nmi_pin_req | illegal_opcode_in | software_trap_in;
        mk_any  = ~global_mask_in & |m_req;
        start   = (q.st == ST_IDLE) && q.strap_done && instr_done_in
                && (nm_any || mk_any);
        prom    = promoted_src(q.psel);
        win     = 4'h0;
        for (int i = NUM_MASKABLE - 1; i >= 0; i--)
        begin
            if (m_req[i])
                win = 4'(i);
        end
        if (m_req[prom])
            win = prom;
        if (clock_monitor_fail_in & clock_monitor_enable_in)
            pick_vec = VEC_CLKMON;
        else if (watchdog_fail_in & ~watchdog_disable_in)
            pick_vec = VEC_WATCHDOG;
        else if (nmi_pin_req)
            pick_vec = VEC_NMI_PIN;
        else if (illegal_opcode_in)
            pick_vec = VEC_ILLEGAL;
        else if (software_trap_in)
            pick_vec = VEC_SW_TRAP;
        else
            pick_vec = 16'(VEC_IRQ - VEC_STEP * {12'h000, win});
    end

    // =========================================================
    // Next state
    // =========================================================
    logic       aw_fire;
    logic       w_fire;
    logic       wr_go;
    logic [7:0] reg_val;

    always_comb
    begin
        d        = q;
        aw_fire  = s_axi_awvalid_in & q.awready;
        w_fire   = s_axi_wvalid_in & q.wready;
        wr_go    = !q.awready && !q.wready && !q.bvalid;
        reg_val  = {q.boot & q.special, q.special, q.mode_a, q.vis, q.psel};
        d.stack_we  = 1'b0;
        d.stack_re  = 1'b0;
        d.set_i     = 1'b0;
        d.set_x     = 1'b0;
        d.vec_valid = 1'b0;

        // Mode straps are caught on the first edge after reset release.
        if (!q.strap_done)
        begin
            d.strap_done = 1'b1;
            d.special    = ~mode_pin_b_in;
            d.mode_a     = mode_pin_a_in;
            d.boot       = ~mode_pin_b_in & ~mode_pin_a_in;
            d.vis        = ~mode_pin_b_in & mode_pin_a_in;
        end
        d.read_vis   = q.vis & q.mode_a;
        d.clk_out_en = q.vis & ~q.mode_a;

        // Receive-full flag; a new arrival wins over the clearing read.
        if (sci_status_rd_in && q.rx_full)
            d.rx_armed = 1'b1;
        if (sci_data_rd_in && q.rx_armed)
        begin
            d.rx_full  = 1'b0;
            d.rx_armed = 1'b0;
        end
        if (rx_full_set_in)
            d.rx_full = 1'b1;

        // AXI4-Lite write: address and data in either order.
        if (aw_fire)
        begin
            d.awready = 1'b0;
            d.aw_hit  = (s_axi_awaddr_in == ADDR_PRIO_CTRL);
        end
        if (w_fire)
        begin
            d.wready = 1'b0;
            d.wbyte  = s_axi_wdata_in[7:0];
            d.wlane0 = s_axi_wstrb_in[0];
        end
        if (wr_go)
        begin
            d.bvalid = 1'b1;
            d.bresp  = q.aw_hit ? RESP_OKAY : RESP_SLVERR;
            if (q.aw_hit && q.wlane0)
            begin
                d.vis = q.wbyte[BIT_VIS];
                if (q.special)
                    d.boot = q.wbyte[BIT_BOOT];
                if (global_mask_in)
                    d.psel = q.wbyte[3:0];
            end
        end
        if (q.bvalid && s_axi_bready_in)
        begin
            d.bvalid  = 1'b0;
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end

        // AXI4-Lite read.
        if (s_axi_arvalid_in && q.arready)
        begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rdata   = (s_axi_araddr_in == ADDR_PRIO_CTRL) ? {24'h000000, reg_val} : 32'h0;
            d.rresp   = (s_axi_araddr_in == ADDR_PRIO_CTRL) ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rvalid && s_axi_rready_in)
        begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end

        // Stacking, vectoring and return.
        unique case (q.st)
            ST_IDLE:
            begin
                if (start)
                begin
                    d.st    = ST_PUSH;
                    d.step  = 4'h0;
                    d.sp    = stack_pointer_in;
                    d.frame = frame_in;
                    d.vec   = pick_vec;
                    d.sel_x = nmi_pin_req;
                    d.busy  = 1'b1;
                end
                else if (return_in && q.strap_done)
                begin
                    d.st   = ST_PULL;
                    d.step = 4'h0;
                    d.sp   = stack_pointer_in;
                    d.busy = 1'b1;
                end
            end
            ST_PUSH:
            begin
                d.stack_we   = 1'b1;
                d.stack_addr = 16'(q.sp - {12'h000, q.step});
                d.stack_data = q.frame[{q.step, 3'b000} +: 8];
                d.step       = 4'(q.step + 4'h1);
                if (q.step == STACK_LAST)
                    d.st = ST_VECTOR;
            end
            ST_VECTOR:
            begin
                d.set_i     = 1'b1;
                d.set_x     = q.sel_x;
                d.vec_valid = 1'b1;
                d.vector    = q.vec;
                d.busy      = 1'b0;
                d.st        = ST_IDLE;
            end
            ST_PULL:
            begin
                d.stack_re    = 1'b1;
                d.stack_addr  = 16'(q.sp + {12'h000, q.step} + 16'h0001);
                d.restore_idx = 4'(STACK_LAST - q.step);
                d.step        = 4'(q.step + 4'h1);
                if (q.step == STACK_LAST)
                begin
                    d.st   = ST_IDLE;
                    d.busy = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q         <= '0;
            q.st      <= ST_IDLE;
            q.psel    <= PSEL_RESET;
            q.awready <= 1'b1;
            q.wready  <= 1'b1;
            q.arready <= 1'b1;
            q.vector  <= VEC_RESET;
        end
        else
            q <= d;
    end

    assign s_axi_awready_out    = q.awready;
    assign s_axi_wready_out     = q.wready;
    assign s_axi_bvalid_out     = q.bvalid;
    assign s_axi_bresp_out      = q.bresp;
    assign s_axi_arready_out    = q.arready;
    assign s_axi_rvalid_out     = q.rvalid;
    assign s_axi_rdata_out      = q.rdata;
    assign s_axi_rresp_out      = q.rresp;
    assign stack_we_out         = q.stack_we;
    assign stack_re_out         = q.stack_re;
    assign stack_addr_out       = q.stack_addr;
    assign stack_data_out       = q.stack_data;
    assign restore_idx_out      = q.restore_idx;
    assign set_global_mask_out  = q.set_i;
    assign set_x_mask_out       = q.set_x;
    assign vector_valid_out     = q.vec_valid;
    assign vector_addr_out      = q.vector;
    assign busy_out             = q.busy;
    assign read_visible_out     = q.read_vis;
    assign clock_out_enable_out = q.clk_out_en;
    assign rx_full_out          = q.rx_full;

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_entry;
        (q.st == ST_IDLE) && start;
    endsequence
    sequence s_push_run;
        stack_we_out [*8] ##1 stack_we_out && stack_addr_out == q.sp - 16'h0008;
    endsequence

    property p_strap_special;
        $rose(q.strap_done) |-> q.special == !$past(mode_pin_b_in);
    endproperty
    a_strap_special: assert property (p_strap_special) else $error("special flag wrong");
    property p_strap_mode_a;
        $rose(q.strap_done) |-> q.mode_a == $past(mode_pin_a_in);
    endproperty
    a_strap_mode_a: assert property (p_strap_mode_a) else $error("mode a flag wrong");
    property p_boot_zero;
        s_axi_rvalid_out && !q.special |-> !s_axi_rdata_out[BIT_BOOT];
    endproperty
    a_boot_zero: assert property (p_boot_zero) else $error("boot bit visible");
    property p_psel_locked;
        q.strap_done && !global_mask_in && !q.bvalid && !q.awready && !q.wready
            |=> $stable(q.psel);
    endproperty
    a_psel_locked: assert property (p_psel_locked) else $error("selector written unmasked");
    property p_psel_reset;
        $rose(q.strap_done) |-> q.psel == PSEL_RESET;
    endproperty
    a_psel_reset: assert property (p_psel_reset) else $error("selector reset wrong");
    property p_entry_gate;
        s_entry |-> instr_done_in && (nm_any || !global_mask_in);
    endproperty
    a_entry_gate: assert property (p_entry_gate) else $error("entry not gated");
    property p_push_order;
        s_entry ##1 1'b1 |=> stack_we_out && stack_addr_out == q.sp
            && stack_data_out == q.frame[7:0] ##0 s_push_run;
    endproperty
    a_push_order: assert property (p_push_order) else $error("stacking order wrong");
    property p_mask_after;
        s_entry |-> ##11 set_global_mask_out && vector_valid_out;
    endproperty
    a_mask_after: assert property (p_mask_after) else $error("mask not set after stack");
    property p_vis_mode;
        q.strap_done ##1 1'b1 |-> read_visible_out == $past(q.vis && q.mode_a);
    endproperty
    a_vis_mode: assert property (p_vis_mode) else $error("visibility wrong");
endmodule : ipv_ctrl

/* File: verification/ipv_core_model.sv */
`timescale 1ns/1ps
// Processor side: retires an instruction every fourth cycle and keeps the stacked bytes.
module ipv_core_model (
    input  wire logic        ref_clk_in,
    input  wire logic        stack_we_in,
    input  wire logic [15:0] stack_addr_in,
    input  wire logic [7:0]  stack_data_in,
    output logic             instr_done_out = 1'b0
);
    logic [1:0] cnt_q = 2'h0;
    logic [7:0] mem [16];
    always_ff @(posedge ref_clk_in)
    begin
        cnt_q <= cnt_q + 2'h1;
        instr_done_out <= (cnt_q == 2'h3);
        if (stack_we_in)
            mem[stack_addr_in[3:0]] <= stack_data_in;
    end
endmodule : ipv_core_model

/* File: verification/interrupt_priority_vectoring_bench.sv */
`timescale 1ns/1ps
`define CHK(n,e,g) begin comparisons++; if ((e) !== (g)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module interrupt_priority_vectoring_bench;
    import ipv_pkg::*;
    int n_errors = 0;
    int comparisons = 0;
    logic ref_clk_in = 0, rst_n_in = 0, mode_pin_a_in = 1, mode_pin_b_in = 1;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, rx_full_set_in = 0, return_in = 0;
    logic ext_request_n_in = 1, nonmaskable_request_pin_n_in = 1, sci_status_rd_in = 0;
    logic sci_data_rd_in = 0, illegal_opcode_in = 0, software_trap_in = 0;
    logic watchdog_fail_in = 0, watchdog_disable_in = 0, clock_monitor_fail_in = 0;
    logic clock_monitor_enable_in = 0, global_mask_in = 1, x_mask_in = 1;
    logic [31:0] s_axi_awaddr_in = 0, s_axi_wdata_in = 0, s_axi_araddr_in = 0;
    logic [31:0] s_axi_rdata_out, rdv;
    logic [3:0] s_axi_wstrb_in = 4'hf, sci_flag_in = 0, sci_enable_in = 0, restore_idx_out;
    logic [12:0] periph_flag_in = 0, periph_enable_in = 13'h1fff;
    logic [15:0] stack_pointer_in = 16'h0020, stack_addr_out, vector_addr_out;
    logic [71:0] frame_in = 72'h18_1716_1514_1312_1110;
    logic [7:0] stack_data_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, stack_we_out, stack_re_out, set_global_mask_out, set_x_mask_out;
    logic vector_valid_out, busy_out, read_visible_out, clock_out_enable_out, rx_full_out;
    wire logic instr_done_in;
    ipv_ctrl ipv_ctrl_inst (.*);
    ipv_core_model ipv_core_model_inst (.ref_clk_in, .stack_we_in(stack_we_out),
        .stack_addr_in(stack_addr_out), .stack_data_in(stack_data_out),
        .instr_done_out(instr_done_in));
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_awvalid_in, s_axi_wvalid_in,
            s_axi_bready_in} <= {a, d, 3'b111};
        do
        begin
            @(posedge ref_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 0;
        end while (!s_axi_bvalid_out);
        s_axi_bready_in <= 0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge ref_clk_in);
        {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {a, 2'b11};
        do
        begin
            @(posedge ref_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 0;
        end while (!s_axi_rvalid_out);
        {rdv, rsp} = {s_axi_rdata_out, s_axi_rresp_out};
        s_axi_rready_in <= 0;
    endtask : rd
    task automatic t_reg;
        rd(ADDR_PRIO_CTRL);
        `CHK("reset value", 32'h26, rdv)
        global_mask_in <= 0;
        wr(ADDR_PRIO_CTRL, 32'h05);
        rd(ADDR_PRIO_CTRL);
        `CHK("unmasked write", 32'h26, rdv)
        global_mask_in <= 1;
        wr(ADDR_PRIO_CTRL, 32'hd0);
        rd(ADDR_PRIO_CTRL);
        `CHK("masked write", 32'h30, rdv)
        `CHK("visibility", 2'b10, {read_visible_out, clock_out_enable_out})
        rd(32'h0);
        `CHK("unmapped", RESP_SLVERR, rsp)
    endtask : t_reg
    task automatic t_entry(input logic [12:0] f, input logic nm, input logic [15:0] v);
        int hits = 0;
        {periph_flag_in, nonmaskable_request_pin_n_in, x_mask_in} <= {f, ~nm, ~nm};
        repeat (16) @(posedge ref_clk_in) hits += vector_valid_out;
        `CHK("entry while masked", nm, hits != 0)
        global_mask_in <= 0;
        do @(posedge ref_clk_in); while (!vector_valid_out);
        `CHK("vector", v, vector_addr_out)
        `CHK("masks set", {1'b1, nm}, {set_global_mask_out, set_x_mask_out})
        {periph_flag_in, nonmaskable_request_pin_n_in, x_mask_in, global_mask_in} <=
            {13'h0, 3'b111};
        repeat (12) @(posedge ref_clk_in);
        for (int k = 0; k < 9; k++)
            `CHK("stacked", frame_in[8*k+:8], ipv_core_model_inst.mem[4'(32'h20 - k)])
    endtask : t_entry
    task automatic t_rx;
        @(posedge ref_clk_in) rx_full_set_in <= 1;
        @(posedge ref_clk_in) {rx_full_set_in, sci_data_rd_in} <= 2'b01;
        @(posedge ref_clk_in) sci_data_rd_in <= 0;
        repeat (2) @(posedge ref_clk_in);
        `CHK("rx full kept", 1'b1, rx_full_out)
        @(posedge ref_clk_in) sci_status_rd_in <= 1;
        @(posedge ref_clk_in) {sci_status_rd_in, sci_data_rd_in} <= 2'b01;
        @(posedge ref_clk_in) sci_data_rd_in <= 0;
        repeat (2) @(posedge ref_clk_in);
        `CHK("rx full cleared", 1'b0, rx_full_out)
    endtask : t_rx
    task automatic t_ret;
        @(posedge ref_clk_in) return_in <= 1;
        @(posedge ref_clk_in) return_in <= 0;
        @(posedge ref_clk_in);
        for (int k = 0; k < 9; k++)
        begin
            @(posedge ref_clk_in);
            `CHK("pull strobe", 1'b1, stack_re_out)
            `CHK("pull addr", 16'(16'h0021 + k), stack_addr_out)
            `CHK("pull index", 4'(8 - k), restore_idx_out)
            if (k == 0) `CHK("busy", 1'b1, busy_out)
        end
        @(posedge ref_clk_in);
        `CHK("pull done", 2'b00, {stack_re_out, busy_out})
    endtask : t_ret
    task automatic conclude;
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial forever #5 ref_clk_in = ~ref_clk_in;
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1;
        repeat (3) @(posedge ref_clk_in);
        t_reg();
        t_entry(13'h210, 0, 16'hffde);
        t_entry(13'h010, 0, 16'hffe8);
        t_entry(13'h210, 1, VEC_NMI_PIN);
        t_rx();
        t_ret();
        conclude();
    end
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule : interrupt_priority_vectoring_bench
